// file: rx_startup_restart_control.v
// transmit/receive startup timing, gain/correction launch and receiver restart control
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rx_startup_map.vh"

module rx_startup_restart_control #(
  parameter CYCLES_PER_US = `CLK_MHZ
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire strength_irq,
  input wire preamble_seen,
  input wire payload_available,
  input wire buffer_empty,
  input wire [2:0] agc_gain,
  output reg synth_enable_ff,
  output reg rx_chain_enable_ff,
  output reg synth_relock_ff,
  output reg tx_ready_ff,
  output reg rx_ready_ff,
  output reg strength_sample_valid_ff,
  output reg gain_start_ff,
  output reg freq_correct_start_ff,
  output reg [2:0] lna_gain_ff,
  output reg mode_settled_ff
);
  localparam ST_IDLE = 8'h01;
  localparam ST_TX_WAIT = 8'h02;
  localparam ST_TX_ON = 8'h04;
  localparam ST_RX_WAIT = 8'h08;
  localparam ST_RX_ON = 8'h10;
  localparam ST_RELOCK = 8'h20;
  localparam ST_DRAIN = 8'h40;
  localparam ST_GAP = 8'h80;
  localparam [15:0] TICK_LAST = CYCLES_PER_US - 1;

  reg [2:0] op_mode_ff;
  reg ook_ff;
  reg [2:0] rx_start_trigger_ff;
  reg auto_gain_enable_ff;
  reg auto_freq_correct_enable_ff;
  reg [4:0] rx_channel_bandwidth_ff;
  reg [4:0] correction_phase_bandwidth_ff;
  reg [1:0] strength_averaging_ff;
  reg [2:0] front_gain_select_ff;
  reg [11:0] amp_ramp_time_ff;
  reg [11:0] bit_time_ff;
  reg [1:0] auto_rx_restart_select_ff;
  reg [15:0] inter_packet_wait_ff;
  reg [23:0] carrier_ff;
  reg freq_changed_ff;
  reg same_req_ff;
  reg relock_req_ff;
  reg [7:0] aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg [7:0] state_ff;
  reg [7:0] nxt_state;
  reg [15:0] tick_cnt_ff;
  reg us_tick_ff;
  reg arm_ff;
  reg pay_d_ff;
  reg t_load;
  reg [15:0] t_val;
  reg in_mode;
  wire t_done;
  wire s_done;
  wire [15:0] startup_us;
  wire wr_go;
  wire [31:0] wr_val;
  wire cmd_rx;
  wire cmd_tx;
  wire trig_hit;
  wire restart_ok;
  wire enter_rx_on;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  function [31:0] image;
    input [7:0] addr;
    begin
      case (addr)
        `REG_MODE: image = {28'h0000000, ook_ff, op_mode_ff};
        `REG_RX_CONFIG: image = {27'h0000000, auto_freq_correct_enable_ff,
                                 auto_gain_enable_ff, rx_start_trigger_ff};
        `REG_BANDWIDTH: image = {14'h0000, strength_averaging_ff, 3'h0,
                                 correction_phase_bandwidth_ff, 3'h0, rx_channel_bandwidth_ff};
        `REG_FRONT_AMP: image = {29'h00000000, front_gain_select_ff};
        `REG_TX_TIMING: image = {4'h0, bit_time_ff, 4'h0, amp_ramp_time_ff};
        `REG_SYNC_CONFIG: image = {8'h00, inter_packet_wait_ff, 6'h00, auto_rx_restart_select_ff};
        `REG_CARRIER: image = {8'h00, carrier_ff};
        `REG_STATUS: image = {16'h0000, state_ff, freq_changed_ff, lna_gain_ff,
                              strength_sample_valid_ff, rx_ready_ff, tx_ready_ff, mode_settled_ff};
        default: image = 32'h00000000;
      endcase
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[1:0] == 2'h0) && (addr <= `REG_STATUS);
    end
  endfunction

  // transmit startup in microseconds; ramp term dropped for on-off keying
  function [15:0] tx_delay_us;
    input ook;
    input [11:0] ramp;
    input [11:0] tbit;
    begin
      tx_delay_us = `TX_FIXED_US + {4'h0, tbit[11:1]} + 16'h0000;
      if (!ook)
        tx_delay_us = tx_delay_us + {4'h0, ramp} + {6'h00, ramp[11:2]};
    end
  endfunction

  // averaging doubles the settle time per step; with no averaging it is a quarter of startup
  function [15:0] strength_delay_us;
    input [15:0] base;
    input [1:0] avg;
    begin
      strength_delay_us = {3'h0, base[15:3]} << (avg + 3'h1);
    end
  endfunction

  // correction bandwidth governs startup when automatic correction is on
  startup_table u_table (
    .bw_code(auto_freq_correct_enable_ff ? correction_phase_bandwidth_ff :
             rx_channel_bandwidth_ff),
    .startup_us(startup_us)
  );

  us_timer u_state_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .us_tick(us_tick_ff),
    .load(t_load),
    .load_us(t_val),
    .done_ff(t_done)
  );

  us_timer u_strength_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .us_tick(us_tick_ff),
    .load(enter_rx_on),
    .load_us(strength_delay_us(startup_us, strength_averaging_ff)),
    .done_ff(s_done)
  );

  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_val = merge(image(aw_addr_ff), w_data_ff, w_strb_ff);
  assign cmd_rx = (op_mode_ff == `MODE_RX);
  assign cmd_tx = (op_mode_ff == `MODE_TX);
  assign enter_rx_on = state_ff[3] && t_done && cmd_rx;
  assign restart_ok = mode_settled_ff && state_ff[4] && cmd_rx;
  assign trig_hit = ((rx_start_trigger_ff == `TRIG_STRENGTH) && strength_irq) ||
                    ((rx_start_trigger_ff == `TRIG_PREAMBLE) && preamble_seen) ||
                    ((rx_start_trigger_ff == `TRIG_EITHER) && (strength_irq || preamble_seen));

  // bus slave: address and data taken in either order, write once both held
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr_ff) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= image(s_axi_araddr);
        s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // control registers; restart bits live one cycle only
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      op_mode_ff <= 3'h1;
      ook_ff <= 1'b0;
      {auto_freq_correct_enable_ff, auto_gain_enable_ff, rx_start_trigger_ff} <= 5'h00;
      rx_channel_bandwidth_ff <= 5'h0B;
      correction_phase_bandwidth_ff <= 5'h0B;
      strength_averaging_ff <= 2'h0;
      front_gain_select_ff <= 3'h1;
      amp_ramp_time_ff <= 12'h028;
      bit_time_ff <= 12'h014;
      auto_rx_restart_select_ff <= `AUTO_OFF;
      inter_packet_wait_ff <= 16'h0000;
      carrier_ff <= 24'h000000;
      freq_changed_ff <= 1'b0;
      same_req_ff <= 1'b0;
      relock_req_ff <= 1'b0;
    end else begin
      same_req_ff <= 1'b0;
      relock_req_ff <= 1'b0;
      // a new receive period forgets the old carrier change unless rewritten now
      if (nxt_state == ST_RX_WAIT && !state_ff[3])
        freq_changed_ff <= 1'b0;
      if (wr_go) begin
        case (aw_addr_ff)
          `REG_MODE: begin
            op_mode_ff <= wr_val[2:0];
            ook_ff <= wr_val[`MODE_OOK_BIT];
          end
          `REG_RX_CONFIG: begin
            rx_start_trigger_ff <= wr_val[2:0];
            auto_gain_enable_ff <= wr_val[`RXC_AGC_BIT];
            auto_freq_correct_enable_ff <= wr_val[`RXC_AFC_BIT];
            same_req_ff <= wr_val[`RXC_SAME_BIT];
            relock_req_ff <= wr_val[`RXC_RELOCK_BIT];
          end
          `REG_BANDWIDTH: begin
            rx_channel_bandwidth_ff <= wr_val[4:0];
            correction_phase_bandwidth_ff <= wr_val[`BW_CORR_LSB +: 5];
            strength_averaging_ff <= wr_val[`BW_AVG_LSB +: 2];
          end
          `REG_FRONT_AMP: front_gain_select_ff <= wr_val[2:0];
          `REG_TX_TIMING: begin
            amp_ramp_time_ff <= wr_val[11:0];
            bit_time_ff <= wr_val[`TXT_BIT_LSB +: 12];
          end
          `REG_SYNC_CONFIG: begin
            auto_rx_restart_select_ff <= wr_val[1:0];
            inter_packet_wait_ff <= wr_val[`SYNC_WAIT_LSB +: 16];
          end
          `REG_CARRIER: begin
            carrier_ff <= wr_val[23:0];
            freq_changed_ff <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // sequencing; a mode change always reroutes, startup, gap and relock moves wait for the timer, restarts and drain do not
  always @* begin
    nxt_state = state_ff;
    t_load = 1'b0;
    t_val = startup_us;
    in_mode = ((state_ff == ST_IDLE) && !cmd_rx && !cmd_tx) ||
              ((state_ff == ST_TX_WAIT || state_ff == ST_TX_ON) && cmd_tx) ||
              (!state_ff[0] && !state_ff[1] && !state_ff[2] && cmd_rx);
    if (!in_mode) begin
      t_load = cmd_rx || cmd_tx;
      if (cmd_rx) begin
        nxt_state = ST_RX_WAIT;
      end else if (cmd_tx) begin
        nxt_state = ST_TX_WAIT;
        t_val = tx_delay_us(ook_ff, amp_ramp_time_ff, bit_time_ff);
      end else begin
        nxt_state = ST_IDLE;
      end
    end else begin
      case (state_ff)
        ST_TX_WAIT: if (t_done) nxt_state = ST_TX_ON;
        ST_RX_WAIT: if (t_done) nxt_state = ST_RX_ON;
        ST_RX_ON: begin
          if (restart_ok && relock_req_ff) begin
            nxt_state = ST_RELOCK;
            t_load = 1'b1;
            t_val = `SYNTH_LOCK_US;
          end else if (restart_ok && same_req_ff) begin
            nxt_state = ST_RX_WAIT;
            t_load = 1'b1;
          end else if (payload_available && !pay_d_ff &&
                       (auto_rx_restart_select_ff == `AUTO_WAIT ||
                        auto_rx_restart_select_ff == `AUTO_RELOCK)) begin
            nxt_state = ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (buffer_empty) begin
            nxt_state = ST_GAP;
            t_load = 1'b1;
            t_val = inter_packet_wait_ff;
          end
        end
        ST_GAP: begin
          if (t_done) begin
            t_load = 1'b1;
            if (auto_rx_restart_select_ff == `AUTO_RELOCK) begin
              nxt_state = ST_RELOCK;
              t_val = `SYNTH_LOCK_US;
            end else begin
              nxt_state = ST_RX_WAIT;
            end
          end
        end
        ST_RELOCK: begin
          if (t_done) begin
            nxt_state = ST_RX_WAIT;
            t_load = 1'b1;
          end
        end
        default: nxt_state = state_ff;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      tick_cnt_ff <= 16'h0000;
      us_tick_ff <= 1'b0;
      arm_ff <= 1'b0;
      pay_d_ff <= 1'b0;
      synth_enable_ff <= 1'b0;
      rx_chain_enable_ff <= 1'b0;
      synth_relock_ff <= 1'b0;
      tx_ready_ff <= 1'b0;
      rx_ready_ff <= 1'b0;
      strength_sample_valid_ff <= 1'b0;
      gain_start_ff <= 1'b0;
      freq_correct_start_ff <= 1'b0;
      lna_gain_ff <= 3'h0;
      mode_settled_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      us_tick_ff <= (tick_cnt_ff == TICK_LAST);
      tick_cnt_ff <= (tick_cnt_ff == TICK_LAST) ? 16'h0000 : tick_cnt_ff + 16'h0001;
      pay_d_ff <= payload_available;
      synth_enable_ff <= (op_mode_ff == `MODE_FSTX) || (op_mode_ff == `MODE_FSRX) ||
                         cmd_tx || cmd_rx;
      rx_chain_enable_ff <= cmd_rx && (nxt_state != ST_RELOCK);
      synth_relock_ff <= (nxt_state == ST_RELOCK) && !state_ff[5];
      tx_ready_ff <= (nxt_state == ST_TX_ON);
      rx_ready_ff <= (nxt_state == ST_RX_ON);
      mode_settled_ff <= (nxt_state == ST_IDLE) || (nxt_state == ST_TX_ON) ||
                         (nxt_state == ST_RX_ON);
      if (nxt_state != ST_RX_ON)
        strength_sample_valid_ff <= 1'b0;
      else if (s_done)
        strength_sample_valid_ff <= 1'b1;
      // one launch per receive start; restarts re-arm through the startup wait
      gain_start_ff <= 1'b0;
      freq_correct_start_ff <= 1'b0;
      if (enter_rx_on) begin
        arm_ff <= 1'b1;
      end else if (state_ff == ST_RX_ON && arm_ff && trig_hit) begin
        arm_ff <= 1'b0;
        gain_start_ff <= auto_gain_enable_ff;
        freq_correct_start_ff <= auto_gain_enable_ff && auto_freq_correct_enable_ff;
      end else if (state_ff != ST_RX_ON) begin
        arm_ff <= 1'b0;
      end
      lna_gain_ff <= auto_gain_enable_ff ? agc_gain : front_gain_select_ff;
    end
  end
endmodule

// file: rx_startup_map.vh
// register map, field positions, reset values and timing for the receiver startup control
`ifndef RX_STARTUP_MAP_VH
`define RX_STARTUP_MAP_VH

`define ADDR_W 8
`define REG_MODE 8'h00
`define REG_RX_CONFIG 8'h04
`define REG_BANDWIDTH 8'h08
`define REG_FRONT_AMP 8'h0C
`define REG_TX_TIMING 8'h10
`define REG_SYNC_CONFIG 8'h14
`define REG_CARRIER 8'h18
`define REG_STATUS 8'h1C

`define MODE_OOK_BIT 3
`define RXC_AGC_BIT 3
`define RXC_AFC_BIT 4
`define RXC_SAME_BIT 5
`define RXC_RELOCK_BIT 6
`define BW_CORR_LSB 8
`define BW_AVG_LSB 16
`define TXT_BIT_LSB 16
`define SYNC_WAIT_LSB 8

`define MODE_FSTX 3'h2
`define MODE_TX 3'h3
`define MODE_FSRX 3'h4
`define MODE_RX 3'h5

`define TRIG_STRENGTH 3'h1
`define TRIG_PREAMBLE 3'h6
`define TRIG_EITHER 3'h7

`define AUTO_OFF 2'h0
`define AUTO_WAIT 2'h1
`define AUTO_RELOCK 2'h2

`define RST_MODE 32'h00000001
`define RST_RX_CONFIG 32'h00000000
`define RST_BANDWIDTH 32'h00000B0B
`define RST_FRONT_AMP 32'h00000001
`define RST_TX_TIMING 32'h00140028
`define RST_SYNC_CONFIG 32'h00000000
`define RST_CARRIER 32'h00000000

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// clock rate in MHz equals cycles per microsecond
`define CLK_MHZ 50
`define TX_FIXED_US 16'h0005
`define SYNTH_LOCK_US 16'h003C
`define RX_STARTUP_FLOOR_US 16'h003F

`endif

// file: us_timer.v
// microsecond down-counter with a one-cycle done pulse
`timescale 1ns/1ps
module us_timer (
  input wire sys_clk,
  input wire sys_rst,
  input wire us_tick,
  input wire load,
  input wire [15:0] load_us,
  output reg done_ff
);
  reg [15:0] count_ff;
  reg busy_ff;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      count_ff <= 16'h0000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (load) begin
        count_ff <= load_us;
        busy_ff <= 1'b1;
      end else if (busy_ff && us_tick) begin
        // a zero load still waits one tick so the state is seen for a cycle
        if (count_ff <= 16'h0001) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          count_ff <= count_ff - 16'h0001;
        end
      end
    end
  end
endmodule

// file: startup_table.v
// receiver startup time in microseconds per bandwidth code
`timescale 1ns/1ps
module startup_table (
  input wire [4:0] bw_code,
  output reg [15:0] startup_us
);
  always @* begin
    case (bw_code)
      5'h00: startup_us = 16'h091A;
      5'h01: startup_us = 16'h0794;
      5'h02: startup_us = 16'h0618;
      5'h03: startup_us = 16'h049C;
      5'h04: startup_us = 16'h03D8;
      5'h05: startup_us = 16'h0317;
      5'h06: startup_us = 16'h0259;
      5'h07: startup_us = 16'h01F8;
      5'h08: startup_us = 16'h0197;
      5'h09: startup_us = 16'h0139;
      5'h0A: startup_us = 16'h0108;
      5'h0B: startup_us = 16'h00D7;
      5'h0C: startup_us = 16'h00A9;
      5'h0D: startup_us = 16'h0090;
      5'h0E: startup_us = 16'h0077;
      5'h0F: startup_us = 16'h0061;
      5'h10: startup_us = 16'h0054;
      5'h11: startup_us = 16'h0047;
      5'h12: startup_us = 16'h0055;
      5'h13: startup_us = 16'h004A;
      default: startup_us = `RX_STARTUP_FLOOR_US;
    endcase
  end
endmodule

// file: rx_startup_restart_control_assertions.sv
// port checker for receiver startup, gain launch and restart sequencing
`timescale 1ns/1ps
module rx_startup_checker #(
  parameter CYCLES_PER_US = 50
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire synth_enable_ff,
  input wire rx_chain_enable_ff,
  input wire synth_relock_ff,
  input wire tx_ready_ff,
  input wire rx_ready_ff,
  input wire strength_sample_valid_ff,
  input wire gain_start_ff,
  input wire freq_correct_start_ff,
  input wire mode_settled_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_chain_synth; rx_chain_enable_ff |-> synth_enable_ff; endproperty
  a_chain_synth: assert property (p_chain_synth) else $error("chain on, synth off");
  property p_ready_chain; rx_ready_ff |-> rx_chain_enable_ff; endproperty
  a_ready_chain: assert property (p_ready_chain) else $error("ready without chain");
  property p_strength_rise; $rose(strength_sample_valid_ff) |-> rx_ready_ff; endproperty
  a_strength_rise: assert property (p_strength_rise) else $error("sample too early");
  property p_gain_once; gain_start_ff |-> rx_ready_ff ##1 (!gain_start_ff)[*8]; endproperty
  a_gain_once: assert property (p_gain_once) else $error("gain launch misplaced");
  property p_corr_gain; freq_correct_start_ff |-> gain_start_ff; endproperty
  a_corr_gain: assert property (p_corr_gain) else $error("correction without gain");
  property p_relock_hold; synth_relock_ff |=> (!rx_chain_enable_ff && !rx_ready_ff)[*8];
  endproperty
  a_relock_hold: assert property (p_relock_hold) else $error("relock too short");
  property p_settled; (tx_ready_ff || rx_ready_ff) |-> mode_settled_ff; endproperty
  a_settled: assert property (p_settled) else $error("ready but not settled");
  property p_wait_unsettled; rx_chain_enable_ff && !rx_ready_ff |-> !mode_settled_ff;
  endproperty
  a_wait_unsettled: assert property (p_wait_unsettled) else $error("settled in wait");
  property p_tx_excl; tx_ready_ff |-> synth_enable_ff && !rx_chain_enable_ff; endproperty
  a_tx_excl: assert property (p_tx_excl) else $error("tx ready in wrong mode");
endmodule

bind rx_startup_restart_control rx_startup_checker #(.CYCLES_PER_US(CYCLES_PER_US)) i_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .synth_enable_ff(synth_enable_ff),
  .rx_chain_enable_ff(rx_chain_enable_ff), .synth_relock_ff(synth_relock_ff),
  .tx_ready_ff(tx_ready_ff), .rx_ready_ff(rx_ready_ff),
  .strength_sample_valid_ff(strength_sample_valid_ff), .gain_start_ff(gain_start_ff),
  .freq_correct_start_ff(freq_correct_start_ff), .mode_settled_ff(mode_settled_ff));

// file: front_end_model.sv
// behavioural receiver front end: strength, preamble, packet buffer and gain loop
`timescale 1ns/1ps
module front_end_model (
  input wire sys_clk,
  input wire rx_on,
  input wire want_strength,
  input wire want_preamble,
  input wire packet_held,
  input wire [2:0] gain_set,
  output logic strength_irq = 1'b0,
  output logic preamble_seen = 1'b0,
  output logic payload_available = 1'b0,
  output logic buffer_empty = 1'b1,
  output logic [2:0] agc_gain = 3'h0
);
  // events only reach the block while the chain listens; a packet stays until drained
  always @(posedge sys_clk) begin
    strength_irq <= rx_on & want_strength;
    preamble_seen <= rx_on & want_preamble;
    payload_available <= packet_held;
    buffer_empty <= ~packet_held;
    agc_gain <= gain_set;
  end
endmodule

// file: testbench.sv
// self-checking bench for startup timing, gain launch and receiver restarts
`timescale 1ns/1ps
`include "rx_startup_map.vh"
module testbench;
  localparam int US_CYC = 1;
  logic sys_clk = 1'b0, sys_rst = 1'b1, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic want_strength = 1'b0, want_preamble = 1'b0, packet_held = 1'b0;
  logic [2:0] gain_set = 3'h0;
  logic [1:0] resp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire strength_irq, preamble_seen, payload_available, buffer_empty, synth_enable_ff;
  wire rx_chain_enable_ff, synth_relock_ff, tx_ready_ff, rx_ready_ff, strength_sample_valid_ff;
  wire gain_start_ff, freq_correct_start_ff, mode_settled_ff;
  wire [2:0] agc_gain, lna_gain_ff;
  int n_fail = 0, total_checks = 0, seed = 28, n, w, k, t, a, f, g, b, r, ex;
  int st_tab[21] = '{2330, 1940, 1560, 1180, 984, 791, 601, 504, 407, 313, 264, 215, 169,
    144, 119, 97, 84, 71, 85, 74, 63};
  int trig[4] = '{0, 1, 6, 7};
  logic [31:0] rst_tab[7] = '{`RST_MODE, `RST_RX_CONFIG, `RST_BANDWIDTH, `RST_FRONT_AMP,
    `RST_TX_TIMING, `RST_SYNC_CONFIG, `RST_CARRIER};

  rx_startup_restart_control #(.CYCLES_PER_US(US_CYC)) i_rx_startup_restart_control (
    .sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .strength_irq, .preamble_seen, .payload_available, .buffer_empty,
    .agc_gain, .synth_enable_ff, .rx_chain_enable_ff, .synth_relock_ff, .tx_ready_ff,
    .rx_ready_ff, .strength_sample_valid_ff, .gain_start_ff, .freq_correct_start_ff,
    .lna_gain_ff, .mode_settled_ff);
  front_end_model i_front_end_model (.sys_clk, .rx_on(rx_chain_enable_ff), .want_strength,
    .want_preamble, .packet_held, .gain_set, .strength_irq, .preamble_seen,
    .payload_available, .buffer_empty, .agc_gain);

  initial forever #10 sys_clk = ~sys_clk;

  task automatic results;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // measured from the bus handshake, so a few cycles of slack absorb tick jitter
  task automatic chk_time(input string nm, input int e, input int s);
    total_checks++;
    if (s < e - 4 || s > e + 4) begin
      n_fail++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, s);
    end
  endtask
  function automatic logic sig(input int sel);
    case (sel)
      0: sig = tx_ready_ff;
      1: sig = rx_ready_ff;
      2: sig = strength_sample_valid_ff;
      default: sig = gain_start_ff;
    endcase
  endfunction
  task automatic wait_sig(input int sel, input logic lv, input int lim, input bit must,
                          output int cnt);
    for (cnt = 0; cnt < lim && (cnt == 0 || sig(sel) !== lv); cnt++)
      @(posedge sys_clk);
    if (must && cnt == lim) begin
      n_fail++;
      results();
    end
  endtask
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
    int k2;
    @(posedge sys_clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k2 = 0;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k2++;
    end while (k2 < 40 && s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k2 == 40) begin
      n_fail++;
      results();
    end
  endtask
  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
    int k2;
    @(posedge sys_clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k2 = 0;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k2++;
    end while (k2 < 40 && s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k2 == 40) begin
      n_fail++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    axi_wr(ad, d, resp);
  endtask
  function automatic int st_us(input int cd);
    return cd > 20 ? 63 : st_tab[cd];
  endfunction

  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 7; k++) begin
      axi_rd(8'(4 * k), rd, resp);
      chk_val("reset value", rst_tab[k], rd);
    end
    axi_wr(8'h20, 32'h5, resp);
    chk_val("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, resp});
    axi_rd(8'h22, rd, resp);
    chk_val("unmapped read", {30'h0, `RESP_SLVERR}, {rd[29:0], resp});
    for (f = 0; f < 2; f++) begin
      r = 40 + $unsigned($random(seed)) % 160;
      b = $unsigned($random(seed)) % 100;
      wr(`REG_TX_TIMING, {4'h0, 12'(b), 4'h0, 12'(r)});
      wr(`REG_MODE, {28'h0, 1'(f), `MODE_TX});
      wait_sig(0, 1'b1, 800, 1'b1, n);
      ex = f ? 5 + b / 2 : 5 + r + r / 4 + b / 2;
      chk_time("tx startup", ex * US_CYC, n);
      wr(`REG_MODE, 32'h1);
    end
    for (k = 0; k < 5; k++) begin
      r = 9 + $unsigned($random(seed)) % 23;
      g = 9 + $unsigned($random(seed)) % 23;
      a = $unsigned($random(seed)) % 4;
      f = k % 2;
      wr(`REG_BANDWIDTH, {14'h0, 2'(a), 3'h0, 5'(g), 3'h0, 5'(r)});
      wr(`REG_RX_CONFIG, {27'h0, 1'(f), 4'h0});
      wr(`REG_MODE, {29'h0, `MODE_RX});
      wait_sig(1, 1'b1, 3000, 1'b1, n);
      ex = st_us(f ? g : r);
      chk_time("rx startup", ex * US_CYC, n);
      chk_val("rx enables", 32'h3, {30'h0, synth_enable_ff, rx_chain_enable_ff});
      wait_sig(2, 1'b1, 3000, 1'b1, n);
      chk_time("strength delay", ((ex / 8) << (a + 1)) * US_CYC, n);
      wr(`REG_MODE, 32'h1);
    end
    wr(`REG_BANDWIDTH, 32'h00001414);
    for (k = 0; k < 8; k++) begin
      t = trig[k / 2];
      a = $unsigned($random(seed)) % 2;
      f = $unsigned($random(seed)) % 2;
      g = $unsigned($random(seed)) % 8;
      gain_set <= 3'($random(seed));
      wr(`REG_FRONT_AMP, 32'(g));
      wr(`REG_RX_CONFIG, {27'h0, 1'(f), 1'(a), 3'(t)});
      wr(`REG_MODE, {29'h0, `MODE_RX});
      wait_sig(1, 1'b1, 300, 1'b1, n);
      chk_val("applied gain", a ? 32'(gain_set) : 32'(g), 32'(lna_gain_ff));
      want_strength <= (k % 2 == 0);
      want_preamble <= (k % 2 == 1);
      wait_sig(3, 1'b1, 20, 1'b0, n);
      ex = a & ((k % 2) ? t >> 2 : t) & 1;
      chk_val("gain launch", 32'(ex), 32'(n < 20));
      chk_val("corr launch", 32'(ex & f), 32'(n < 20 && freq_correct_start_ff));
      want_strength <= 1'b0;
      want_preamble <= 1'b0;
      wr(`REG_MODE, 32'h1);
    end
    wr(`REG_RX_CONFIG, 32'h0);
    wr(`REG_MODE, {29'h0, `MODE_RX});
    wr(`REG_RX_CONFIG, 32'h00000040);
    wait_sig(1, 1'b1, 300, 1'b1, n);
    chk_time("restart while unsettled", 59 * US_CYC, n);
    wr(`REG_RX_CONFIG, 32'h00000020);
    wait_sig(1, 1'b1, 300, 1'b1, n);
    chk_time("same osc restart", 63 * US_CYC, n);
    wr(`REG_RX_CONFIG, 32'h00000040);
    wait_sig(1, 1'b1, 400, 1'b1, n);
    chk_time("relock restart", 123 * US_CYC, n);
    axi_rd(`REG_RX_CONFIG, rd, resp);
    chk_val("restart bits", 32'h0, rd & 32'h60);
    wait_sig(1, 1'b0, 100, 1'b0, n);
    chk_time("single restart", 100, n);
    for (k = 0; k < 4; k++) begin
      w = 10 + $unsigned($random(seed)) % 40;
      wr(`REG_SYNC_CONFIG, {8'h0, 16'(w), 6'h0, 2'(k)});
      wr(`REG_MODE, 32'h1);
      wr(`REG_MODE, {29'h0, `MODE_RX});
      wait_sig(1, 1'b1, 300, 1'b1, n);
      packet_held <= 1'b1;
      // host stalls before draining, so the block must hold off meanwhile
      repeat (12) @(posedge sys_clk);
      packet_held <= 1'b0;
      repeat (2) @(posedge sys_clk);
      wait_sig(1, 1'b1, 600, 1'b1, n);
      ex = k == 1 ? w + 63 : k == 2 ? w + 123 : 0;
      chk_time("auto restart", ex * US_CYC, n);
    end
    results();
  end
endmodule
